//--- verilog/irq_vec_pkg.sv
// Overview of operation
// - Pin events are detected only while the pin enable bit is 1.
// - Detection follows the polarity bit and the edge-only or edge-and-level mode bit.
// - Software chooses whether a pin event requests an interrupt or only sets the flag.
// - Rising polarity swaps the optional pin pull-up for a pull-down.
// - While enabled, the synchronised pin level is offered to the branch-on-pin logic.
// - A move from the deasserted to the asserted level sets the pin request flag.
// - In edge-and-level mode the flag stays set and refuses clears while the pin is asserted.
// - Each vector is two bytes: handler high byte at the lower address, low byte next.
// - Lower vector numbers win: reset 0, software interrupt 1 at FFFC, pin request 2 at FFFA.
// - The pin request flag forwards a request to the CPU only when its local enable is 1; the clock generator flag has no such gate.
// - Vectors 26 to 31 (FFC0 up to FFCA) have no hardware source and the lowest priority.
// - Reset vector FFFE is shared by gated watchdog, gated low voltage, reset pin, bad opcode.
// - Clock generator vector 4 at FFF6 comes from its flag, set by enabled loss status.
// - Polarity 0 means falling edge or low level, 1 means rising edge or high level.
// - The pin request flag is read-only, 1 when an event is pending and 0 otherwise.
package irq_vec_pkg;

  localparam int unsigned ADDR_W = 4;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned NUM_VEC = 32;
  localparam int unsigned VNUM_W = 5;

  // Register offsets
  localparam logic [3:0] OFS_PIN_SC  = 4'h0;
  localparam logic [3:0] OFS_CLKGEN  = 4'h1;
  localparam logic [3:0] OFS_SYSOPT  = 4'h2;
  localparam logic [3:0] OFS_INT_ST  = 4'h3;
  localparam logic [3:0] OFS_INT_MSK = 4'h4;

  // pin_request_status_control fields
  localparam int unsigned SC_POL_BIT  = 5;
  localparam int unsigned SC_PE_BIT   = 4;
  localparam int unsigned SC_FLAG_BIT = 3;
  localparam int unsigned SC_ACK_BIT  = 2;
  localparam int unsigned SC_IE_BIT   = 1;
  localparam int unsigned SC_MOD_BIT  = 0;

  // Clock generator control fields
  localparam int unsigned CG_LOLE_BIT = 7;
  localparam int unsigned CG_LOCE_BIT = 6;
  localparam int unsigned CG_FLAG_BIT = 1;
  localparam int unsigned CG_ACK_BIT  = 0;

  // System option fields
  localparam int unsigned SO_WDE_BIT  = 7;
  localparam int unsigned SO_LVRE_BIT = 6;

  // Interrupt status event bits
  localparam int unsigned EV_PIN_BIT    = 0;
  localparam int unsigned EV_CLKGEN_BIT = 1;
  localparam int unsigned EV_REFUSE_BIT = 2;
  localparam int unsigned EV_W          = 3;

  // Reset values
  localparam logic       WDE_RST  = 1'b1;
  localparam logic       LVRE_RST = 1'b1;
  localparam logic [2:0] MSK_RST  = 3'h0;

  // Vector map
  localparam logic [4:0]  VEC_RESET   = 5'h00;
  localparam logic [4:0]  VEC_SWI     = 5'h01;
  localparam logic [4:0]  VEC_PIN     = 5'h02;
  localparam logic [4:0]  VEC_CLKGEN  = 5'h04;
  localparam int unsigned VEC_UNUSED0 = 26;
  localparam logic [15:0] VEC_TOP     = 16'hFFFE;

  typedef struct packed {
    logic polarity;
    logic pin_en;
    logic int_en;
    logic level_mode;
  } pin_cfg_t;

  typedef struct packed {
    logic        valid;
    logic [4:0]  num;
    logic [15:0] addr;
  } vec_out_t;

endpackage : irq_vec_pkg

//--- verilog/irq_pin_and_vector_priority.sv
// Implementation choices: the plain strobed port and the placing of the registers.
module irq_pin_and_vector_priority
  import irq_vec_pkg::*;
#(
  parameter int unsigned PERIPH_W = NUM_VEC
) (
  input  wire logic                  mclk_i,
  input  wire logic                  rst_b_i,
  input  wire logic [ADDR_W-1:0]     addr_i,
  input  wire logic [DATA_W-1:0]     wdata_i,
  input  wire logic                  wr_i,
  input  wire logic                  rd_i,
  output      logic [DATA_W-1:0]     rdata_o,
  input  wire logic                  irq_pin_i,
  output      logic                  pull_up_en_o,
  output      logic                  pull_down_en_o,
  output      logic                  pin_level_o,
  output      logic                  pin_level_valid_o,
  input  wire logic                  swi_i,
  input  wire logic [PERIPH_W-1:0]   periph_req_i,
  input  wire logic                  wdog_timeout_i,
  input  wire logic                  low_volt_i,
  input  wire logic                  reset_pin_i,
  input  wire logic                  illegal_op_i,
  input  wire logic                  loss_of_lock_status_i,
  input  wire logic                  loss_of_clock_status_i,
  output      logic                  reset_req_o,
  output      vec_out_t              vec_o,
  output      logic                  int_o
);

  pin_cfg_t            cfg_reg;
  logic                pin_sync1_reg;
  logic                pin_sync_reg;
  logic                prev_asserted_reg;
  logic                pin_request_flag_reg;
  logic                loss_of_lock_enable_reg;
  logic                loss_of_clock_enable_reg;
  logic                clockgen_int_flag_reg;
  logic                watchdog_enable_reg;
  logic                low_voltage_reset_enable_reg;
  logic [EV_W-1:0]     int_st_reg;
  logic [EV_W-1:0]     int_msk_reg;
  logic [DATA_W-1:0]   rdata_reg;
  vec_out_t            vec_reg;
  logic                reset_req_reg;
  logic                int_reg;
  logic                pin_asserted;
  logic                edge_det;
  logic                level_hold;
  logic                pin_ack;
  logic                cg_ack;
  logic                cg_cond;
  logic                refused;
  logic [EV_W-1:0]     events;
  logic [NUM_VEC-1:0]  pending;

  function automatic logic wr_at(input logic [3:0] ofs);
    return wr_i && (addr_i == ofs);
  endfunction : wr_at

  function automatic logic rd_at(input logic [3:0] ofs);
    return rd_i && (addr_i == ofs);
  endfunction : rd_at

  function automatic logic [NUM_VEC-1:0] below(input logic [4:0] n);
    return (NUM_VEC'(1) << n) - NUM_VEC'(1);
  endfunction : below

  // Synchroniser; the first stage feeds only the second
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pin_sync1_reg <= 1'b0;
      pin_sync_reg  <= 1'b0;
    end else begin
      pin_sync1_reg <= irq_pin_i;
      pin_sync_reg  <= pin_sync1_reg;
    end
  end

  assign pin_asserted = cfg_reg.polarity ? pin_sync_reg : !pin_sync_reg;
  assign edge_det     = cfg_reg.pin_en && pin_asserted && !prev_asserted_reg;
  assign level_hold   = cfg_reg.pin_en && cfg_reg.level_mode && pin_asserted;
  // Decoded inline: a continuous assignment would miss strobe changes read inside a function
  assign pin_ack      = wr_i && (addr_i == OFS_PIN_SC) && wdata_i[SC_ACK_BIT];
  assign refused      = pin_ack && level_hold && pin_request_flag_reg;

  // Disabled pin counts as already asserted, so enabling on an asserted level raises no edge
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      prev_asserted_reg <= 1'b1;
    end else begin
      prev_asserted_reg <= cfg_reg.pin_en ? pin_asserted : 1'b1;
    end
  end

  // Configuration registers
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cfg_reg                      <= '0;
      loss_of_lock_enable_reg      <= 1'b0;
      loss_of_clock_enable_reg     <= 1'b0;
      watchdog_enable_reg          <= WDE_RST;
      low_voltage_reset_enable_reg <= LVRE_RST;
      int_msk_reg                  <= MSK_RST;
    end else begin
      if (wr_at(OFS_PIN_SC)) begin
        cfg_reg.polarity   <= wdata_i[SC_POL_BIT];
        cfg_reg.pin_en     <= wdata_i[SC_PE_BIT];
        cfg_reg.int_en     <= wdata_i[SC_IE_BIT];
        cfg_reg.level_mode <= wdata_i[SC_MOD_BIT];
      end
      if (wr_at(OFS_CLKGEN)) begin
        loss_of_lock_enable_reg  <= wdata_i[CG_LOLE_BIT];
        loss_of_clock_enable_reg <= wdata_i[CG_LOCE_BIT];
      end
      if (wr_at(OFS_SYSOPT)) begin
        watchdog_enable_reg          <= wdata_i[SO_WDE_BIT];
        low_voltage_reset_enable_reg <= wdata_i[SO_LVRE_BIT];
      end
      if (wr_at(OFS_INT_MSK)) begin
        int_msk_reg <= wdata_i[EV_W-1:0];
      end
    end
  end

  // Pin request flag: set wins over an acknowledge in the same cycle
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pin_request_flag_reg <= 1'b0;
    end else if (edge_det || level_hold) begin
      pin_request_flag_reg <= 1'b1;
    end else if (pin_ack) begin
      pin_request_flag_reg <= 1'b0;
    end
  end

  // Clock generator flag set by enabled loss status, held until acknowledged
  assign cg_cond = (loss_of_lock_status_i && loss_of_lock_enable_reg)
                || (loss_of_clock_status_i && loss_of_clock_enable_reg);
  assign cg_ack  = wr_i && (addr_i == OFS_CLKGEN) && wdata_i[CG_ACK_BIT];

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      clockgen_int_flag_reg <= 1'b0;
    end else if (cg_cond) begin
      clockgen_int_flag_reg <= 1'b1;
    end else if (cg_ack) begin
      clockgen_int_flag_reg <= 1'b0;
    end
  end

  // Sticky event status, cleared by a read; a new event in the read cycle survives
  assign events = {refused, cg_cond && !clockgen_int_flag_reg, edge_det};

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      int_st_reg <= '0;
    end else if (rd_at(OFS_INT_ST)) begin
      int_st_reg <= events;
    end else begin
      int_st_reg <= int_st_reg | events;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      int_reg <= 1'b0;
    end else begin
      int_reg <= |((int_st_reg | events) & int_msk_reg);
    end
  end

  // Register read port, data one cycle after the strobe
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rdata_reg <= '0;
    end else if (rd_i) begin
      rdata_reg <= '0;
      case (addr_i)
        OFS_PIN_SC: begin
          rdata_reg[SC_POL_BIT]  <= cfg_reg.polarity;
          rdata_reg[SC_PE_BIT]   <= cfg_reg.pin_en;
          rdata_reg[SC_FLAG_BIT] <= pin_request_flag_reg;
          rdata_reg[SC_IE_BIT]   <= cfg_reg.int_en;
          rdata_reg[SC_MOD_BIT]  <= cfg_reg.level_mode;
        end
        OFS_CLKGEN: begin
          rdata_reg[CG_LOLE_BIT] <= loss_of_lock_enable_reg;
          rdata_reg[CG_LOCE_BIT] <= loss_of_clock_enable_reg;
          rdata_reg[CG_FLAG_BIT] <= clockgen_int_flag_reg;
        end
        OFS_SYSOPT: begin
          rdata_reg[SO_WDE_BIT]  <= watchdog_enable_reg;
          rdata_reg[SO_LVRE_BIT] <= low_voltage_reset_enable_reg;
        end
        OFS_INT_ST: begin
          rdata_reg[EV_W-1:0] <= int_st_reg;
        end
        OFS_INT_MSK: begin
          rdata_reg[EV_W-1:0] <= int_msk_reg;
        end
        default: begin
          rdata_reg <= '0;
        end
      endcase
    end
  end

  // Pending sources; peripheral lines arrive already gated by their own enables
  always_comb begin
    pending = '0;
    for (int i = 0; i < VEC_UNUSED0; i++) begin
      pending[i] = (i < PERIPH_W) ? periph_req_i[i] : 1'b0;
    end
    pending[VEC_RESET]  = 1'b0;
    pending[VEC_SWI]    = swi_i;
    pending[VEC_PIN]    = pin_request_flag_reg && cfg_reg.int_en;
    pending[VEC_CLKGEN] = clockgen_int_flag_reg;
  end

  // Lowest pending number wins; reset is never pending here and goes out on reset_req_o
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      vec_reg       <= '0;
      reset_req_reg <= 1'b0;
    end else begin
      reset_req_reg <= (wdog_timeout_i && watchdog_enable_reg)
                    || (low_volt_i && low_voltage_reset_enable_reg)
                    || reset_pin_i || illegal_op_i;
      vec_reg.valid <= |pending;
      vec_reg.num   <= VEC_RESET;
      vec_reg.addr  <= VEC_TOP;
      for (int i = NUM_VEC - 1; i >= 1; i--) begin
        if (pending[i]) begin
          vec_reg.num  <= VNUM_W'(i);
          vec_reg.addr <= VEC_TOP - {10'h000, VNUM_W'(i), 1'b0};
        end
      end
    end
  end

  assign rdata_o           = rdata_reg;
  assign vec_o             = vec_reg;
  assign reset_req_o       = reset_req_reg;
  assign int_o             = int_reg;
  assign pull_up_en_o      = cfg_reg.pin_en && !cfg_reg.polarity;
  assign pull_down_en_o    = cfg_reg.pin_en && cfg_reg.polarity;
  assign pin_level_o       = cfg_reg.pin_en ? pin_sync_reg : 1'b0;
  assign pin_level_valid_o = cfg_reg.pin_en;

  sequence s_pin_rise;
    $rose(irq_pin_i) ##1 irq_pin_i;
  endsequence

  sequence s_wdog_fire;
    wdog_timeout_i && watchdog_enable_reg;
  endsequence

  a_pin_sync_delay: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    s_pin_rise |-> ##1 pin_sync_reg)
    else $error("pin level not seen two cycles after change");

  a_edge_sets_flag: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    edge_det |=> pin_request_flag_reg)
    else $error("detected edge did not set the flag");

  a_disabled_no_event: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    !cfg_reg.pin_en |-> !edge_det)
    else $error("edge detected while pin disabled");

  a_level_holds_flag: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    level_hold && pin_ack |=> pin_request_flag_reg)
    else $error("flag cleared while level still asserted");

  a_polarity_falling: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    edge_det && !cfg_reg.polarity && $stable(cfg_reg.polarity) |-> $fell(pin_sync_reg))
    else $error("falling polarity fired on a high pin");

  a_pull_select: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    cfg_reg.pin_en |-> (pull_down_en_o == cfg_reg.polarity) && (pull_up_en_o != pull_down_en_o))
    else $error("pull resistor does not follow polarity");

  a_pin_level_seen: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    pin_level_valid_o |-> pin_level_o == $past(irq_pin_i, 2))
    else $error("branch level differs from pin");

  a_pin_req_gated: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    vec_o.valid && vec_o.num == VEC_PIN |-> $past(pin_request_flag_reg && cfg_reg.int_en))
    else $error("pin vector requested without enabled flag");

  a_vec_addr_form: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    vec_o.valid |-> vec_o.addr == VEC_TOP - {10'h000, vec_o.num, 1'b0})
    else $error("vector address does not match number");

  a_vec_priority: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    vec_o.valid |-> (($past(pending) & below(vec_o.num)) == '0)
                    && ((($past(pending) >> vec_o.num) & NUM_VEC'(1)) != '0))
    else $error("a higher priority source was passed over");

  a_unused_vectors: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    vec_o.valid |-> vec_o.num < VNUM_W'(VEC_UNUSED0))
    else $error("unused vector selected");

  a_reset_shared: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    s_wdog_fire or (illegal_op_i ##0 1'b1) |=> reset_req_o)
    else $error("reset source did not raise reset request");

  a_clkgen_flag: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    cg_cond |=> clockgen_int_flag_reg ##1 (vec_o.valid && vec_o.num <= VEC_CLKGEN))
    else $error("clock generator loss did not request vector 4");

  a_flag_readback: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    rd_at(OFS_PIN_SC) |=> rdata_o[SC_FLAG_BIT] == $past(pin_request_flag_reg))
    else $error("flag read back wrong");

endmodule : irq_pin_and_vector_priority

//--- testbench/cpu_core_model.sv
module cpu_core_model
  import irq_vec_pkg::*;
(
  input  wire logic        mclk_i,
  input  wire logic        rst_b_i,
  input  wire vec_out_t    vec_i,
  input  wire logic        mask_clr_i,
  output      logic        global_mask_o,
  output      logic [15:0] fetch_addr_o,
  output      logic [3:0]  taken_o
);
  timeunit 1ns;
  timeprecision 100ps;

  logic [2:0] step_reg;

  // Steps 1 to 5 push PC low, PC high, X, A, CONDITION_CODE_REGISTER; the vector is latched last,
  // so a source that became pending during stacking still wins if it ranks higher
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      global_mask_o <= 1'b1;
      step_reg      <= 3'h0;
      fetch_addr_o  <= 16'h0000;
      taken_o       <= 4'h0;
    end else if (step_reg != 3'h0) begin
      if (step_reg == 3'h5) begin
        global_mask_o <= 1'b1;
        fetch_addr_o  <= vec_i.addr;
        taken_o       <= taken_o + 4'h1;
        step_reg      <= 3'h0;
      end else begin
        step_reg <= step_reg + 3'h1;
      end
    end else if (mask_clr_i) begin
      global_mask_o <= 1'b0;
    end else if (!global_mask_o && vec_i.valid) begin
      step_reg <= 3'h1;
    end
  end
endmodule : cpu_core_model

//--- testbench/test_irq_pin_and_vector_priority.sv
module test_irq_pin_and_vector_priority;
  import irq_vec_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;

  logic        mclk_i = 1'b0;
  logic        rst_b_i = 1'b0;
  logic [3:0]  addr_i = 4'h0;
  logic [7:0]  wdata_i = 8'h00;
  logic        wr_i = 1'b0;
  logic        rd_i = 1'b0;
  logic [7:0]  rdata_o;
  logic        irq_pin_i = 1'b1;
  logic        pull_up_en_o;
  logic        pull_down_en_o;
  logic        pin_level_o;
  logic        pin_level_valid_o;
  logic        swi_i = 1'b0;
  logic [31:0] periph = 32'h0000_0000;
  logic [3:0]  rsrc = 4'h0;
  logic        lol = 1'b0;
  logic        loc = 1'b0;
  logic        reset_req_o;
  vec_out_t    vec_o;
  logic        int_o;
  logic        mask_clr = 1'b0;
  logic        gmask;
  logic [15:0] fetch_addr;
  logic [3:0]  taken;
  int          fails = 0;
  int          compares = 0;

  always #5 mclk_i = ~mclk_i;

  irq_pin_and_vector_priority irq_pin_and_vector_priority_i (
    .mclk_i(mclk_i), .rst_b_i(rst_b_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
    .rd_i(rd_i), .rdata_o(rdata_o), .irq_pin_i(irq_pin_i), .pull_up_en_o(pull_up_en_o),
    .pull_down_en_o(pull_down_en_o), .pin_level_o(pin_level_o),
    .pin_level_valid_o(pin_level_valid_o), .swi_i(swi_i), .periph_req_i(periph),
    .wdog_timeout_i(rsrc[3]), .low_volt_i(rsrc[2]), .reset_pin_i(rsrc[1]),
    .illegal_op_i(rsrc[0]), .loss_of_lock_status_i(lol), .loss_of_clock_status_i(loc),
    .reset_req_o(reset_req_o), .vec_o(vec_o), .int_o(int_o));

  cpu_core_model cpu_core_model_i (
    .mclk_i(mclk_i), .rst_b_i(rst_b_i), .vec_i(vec_o), .mask_clr_i(mask_clr),
    .global_mask_o(gmask), .fetch_addr_o(fetch_addr), .taken_o(taken));

  task automatic report_and_stop;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : report_and_stop

  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : check

  task automatic tick(input int n);
    repeat (n) @(posedge mclk_i);
    #1;
  endtask : tick

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk_i);
    wr_i    <= 1'b1;
    addr_i  <= a;
    wdata_i <= d;
    @(posedge mclk_i);
    wr_i <= 1'b0;
  endtask : wr

  // Sampled just after the edge that took the strobe; the read data then holds until the next read
  task automatic rdc(input logic [3:0] a, input logic [7:0] exp, input string what);
    @(posedge mclk_i);
    rd_i   <= 1'b1;
    addr_i <= a;
    @(posedge mclk_i);
    rd_i <= 1'b0;
    #1;
    check({8'h00, rdata_o}, {8'h00, exp}, what);
  endtask : rdc

  task automatic pin(input logic v);
    @(posedge mclk_i);
    irq_pin_i <= v;
  endtask : pin

  task automatic vec_is(input logic v, input logic [4:0] n, input logic [15:0] a);
    check({15'h0000, vec_o.valid}, {15'h0000, v}, "vector valid");
    check({11'h000, vec_o.num}, {11'h000, n}, "vector number");
    check(vec_o.addr, a, "vector address");
  endtask : vec_is

  task automatic s_reset;
    rdc(OFS_PIN_SC, 8'h00, "control after reset");
    rdc(OFS_SYSOPT, 8'hC0, "options after reset");
    rdc(OFS_INT_MSK, 8'h00, "mask after reset");
    rdc(4'hF, 8'h00, "unmapped read");
    check({15'h0000, pin_level_valid_o}, 16'h0000, "level valid off");
    check({14'h0000, pull_up_en_o, pull_down_en_o}, 16'h0000, "pulls off");
  endtask : s_reset

  task automatic s_disabled;
    pin(1'b0);
    tick(6);
    rdc(OFS_PIN_SC, 8'h00, "no flag while disabled");
    pin(1'b1);
    tick(6);
    rdc(OFS_INT_ST, 8'h00, "no event while disabled");
    check({15'h0000, pin_level_o}, 16'h0000, "level hidden while disabled");
  endtask : s_disabled

  task automatic s_fall_poll;
    wr(OFS_PIN_SC, 8'h10);
    tick(1);
    check({14'h0000, pull_up_en_o, pull_down_en_o}, 16'h0002, "pull-up for falling");
    pin(1'b0);
    tick(5);
    rdc(OFS_PIN_SC, 8'h18, "falling edge flag");
    check({15'h0000, pin_level_o}, 16'h0000, "level low");
    check({15'h0000, pin_level_valid_o}, 16'h0001, "level valid on");
    check({15'h0000, vec_o.valid}, 16'h0000, "polled only");
    check({15'h0000, int_o}, 16'h0000, "masked event");
    wr(OFS_PIN_SC, 8'h14);
    pin(1'b1);
    tick(5);
    rdc(OFS_PIN_SC, 8'h10, "rising ignored when falling");
    check({15'h0000, pin_level_o}, 16'h0001, "level high");
    rdc(OFS_INT_ST, 8'h01, "edge status");
    wr(OFS_PIN_SC, 8'h00);
  endtask : s_fall_poll

  task automatic s_rise_int;
    int i;
    pin(1'b0);
    tick(3);
    wr(OFS_INT_MSK, 8'h01);
    wr(OFS_PIN_SC, 8'h32);
    tick(1);
    check({14'h0000, pull_up_en_o, pull_down_en_o}, 16'h0001, "pull-down for rising");
    pin(1'b1);
    tick(5);
    rdc(OFS_PIN_SC, 8'h3A, "rising edge flag");
    vec_is(1'b1, 5'h02, 16'hFFFA);
    check({15'h0000, int_o}, 16'h0001, "interrupt raised");
    @(posedge mclk_i);
    mask_clr <= 1'b1;
    @(posedge mclk_i);
    mask_clr <= 1'b0;
    for (i = 0; i < 20 && taken == 4'h0; i++) tick(1);
    if (taken == 4'h0) begin
      fails++;
      report_and_stop();
    end
    check(fetch_addr, 16'hFFFA, "fetched vector");
    check({15'h0000, gmask}, 16'h0001, "mask set on entry");
    rdc(OFS_INT_ST, 8'h01, "status read");
    tick(1);
    check({15'h0000, int_o}, 16'h0000, "cleared by read");
    wr(OFS_PIN_SC, 8'h36);
    tick(4);
    rdc(OFS_PIN_SC, 8'h32, "one edge one event");
    vec_is(1'b0, 5'h00, 16'hFFFE);
    wr(OFS_PIN_SC, 8'h00);
    wr(OFS_INT_MSK, 8'h00);
  endtask : s_rise_int

  task automatic s_level;
    pin(1'b0);
    tick(3);
    wr(OFS_PIN_SC, 8'h31);
    pin(1'b1);
    tick(5);
    wr(OFS_PIN_SC, 8'h35);
    tick(2);
    rdc(OFS_PIN_SC, 8'h39, "ack refused while asserted");
    rdc(OFS_INT_ST, 8'h05, "refusal status");
    pin(1'b0);
    tick(4);
    wr(OFS_PIN_SC, 8'h35);
    rdc(OFS_PIN_SC, 8'h31, "ack after release");
    wr(OFS_PIN_SC, 8'h00);
  endtask : s_level

  task automatic s_clkgen;
    lol <= 1'b1;
    tick(3);
    rdc(OFS_CLKGEN, 8'h00, "loss gated off");
    wr(OFS_CLKGEN, 8'h80);
    tick(3);
    rdc(OFS_CLKGEN, 8'h82, "lock loss flag");
    vec_is(1'b1, 5'h04, 16'hFFF6);
    periph <= 32'h0000_0020;
    tick(2);
    vec_is(1'b1, 5'h04, 16'hFFF6);
    swi_i <= 1'b1;
    tick(2);
    vec_is(1'b1, 5'h01, 16'hFFFC);
    swi_i <= 1'b0;
    lol   <= 1'b0;
    wr(OFS_CLKGEN, 8'h81);
    tick(3);
    vec_is(1'b1, 5'h05, 16'hFFF4);
    periph <= 32'h8400_0000;
    tick(3);
    vec_is(1'b0, 5'h00, 16'hFFFE);
    periph <= 32'h0000_0000;
    rdc(OFS_INT_ST, 8'h02, "clock flag status");
    wr(OFS_CLKGEN, 8'h40);
    loc <= 1'b1;
    tick(3);
    rdc(OFS_CLKGEN, 8'h42, "clock loss flag");
    loc <= 1'b0;
    wr(OFS_CLKGEN, 8'h01);
  endtask : s_clkgen

  task automatic s_reset_src;
    int i;
    for (i = 0; i < 4; i++) begin
      rsrc <= 4'h1 << i;
      tick(3);
      check({15'h0000, reset_req_o}, 16'h0001, "reset source");
      rsrc <= 4'h0;
      tick(3);
      check({15'h0000, reset_req_o}, 16'h0000, "reset source gone");
    end
    wr(OFS_SYSOPT, 8'h40);
    rsrc <= 4'h8;
    tick(3);
    check({15'h0000, reset_req_o}, 16'h0000, "watchdog gated");
    rsrc <= 4'h4;
    tick(3);
    check({15'h0000, reset_req_o}, 16'h0001, "low voltage enabled");
    wr(OFS_SYSOPT, 8'h00);
    tick(3);
    check({15'h0000, reset_req_o}, 16'h0000, "low voltage gated");
    rsrc <= 4'h0;
  endtask : s_reset_src

  initial begin
    repeat (10) @(posedge mclk_i);
    rst_b_i <= 1'b1;
    s_reset();
    s_disabled();
    s_fall_poll();
    s_rise_int();
    s_level();
    s_clkgen();
    s_reset_src();
    report_and_stop();
  end
endmodule : test_irq_pin_and_vector_priority
